// ---- hdl/cfwa_pkg.sv ----
/*
 Constants, types and state codes for the configuration fuse word access block.
 Assumes a single 100 MHz core clock and a 16-bit program/verify port.
*/
package cfwa_pkg;
    // Configuration space
    localparam logic [15:0] CFG_BASE = 16'hfe00;
    localparam logic [15:0] CFG_HIGH_BASE = 16'hfe08;
    localparam logic [15:0] CFG_LAST = 16'hfe0f;
    localparam int CFG_HALF_SEL_BIT = 3;
    localparam int CFG_SPACE_LSB = 4;
    // Fuse locations
    localparam int NUM_FUSES = 7;
    localparam int FUSE_OSC0 = 0;
    localparam int FUSE_OSC1 = 1;
    localparam int FUSE_WDT0 = 2;
    localparam int FUSE_WDT1 = 3;
    localparam int FUSE_PM0 = 4;
    localparam int FUSE_PM1 = 5;
    localparam int FUSE_PM2 = 6;
    localparam logic [15:0] FUSE_ADDR [NUM_FUSES] = '{16'hfe00, 16'hfe01, 16'hfe02, 16'hfe03,
                                                     16'hfe04, 16'hfe06, 16'hfe0f};
    localparam logic [NUM_FUSES-1:0] FUSE_ERASED = 7'h7f;
    // Read positions within the 16-bit configuration word
    localparam int RD_OSC0_POS = 0;
    localparam int RD_OSC1_POS = 1;
    localparam int RD_WDT0_POS = 2;
    localparam int RD_WDT1_POS = 3;
    localparam int RD_PM0_POS = 4;
    localparam int RD_PM1_POS = 6;
    localparam int RD_PM2_POS = 15;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic [7:0] PAD_FILL = 8'hff;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int INSTR_CYCLE_NS = 40;
    localparam int CLKS_PER_INSTR = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_DELAY_INSTR = 3;
    localparam int SAMPLE_DELAY_CLKS = SAMPLE_DELAY_INSTR * CLKS_PER_INSTR;
    localparam logic [7:0] SAMPLE_LAST = 8'(SAMPLE_DELAY_CLKS - 1);
    localparam int SYNC_BITS = 18;
    // Field encodings
    typedef enum logic [1:0] {
        WDT_OFF_16BIT = 2'b00,
        WDT_POST64 = 2'b01,
        WDT_POST256 = 2'b10,
        WDT_POST0 = 2'b11
    } cfwa_wdt_t;
    localparam logic [2:0] PMODE_MICROPROC = 3'h7;
    localparam logic [2:0] PMODE_MICROCTL = 3'h6;
    localparam logic [2:0] PMODE_EXT_MICROCTL = 3'h5;
    localparam logic [2:0] PMODE_PROTECTED = 3'h0;
    typedef enum logic [2:0] {
        ST_LOAD = 3'b000,
        ST_VERIFY = 3'b001,
        ST_PROG_WAIT = 3'b010,
        ST_PROG_HOLD = 3'b011,
        ST_POST_PROG = 3'b100
    } cfwa_state_t;
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } cfwa_pad_t;
    typedef struct packed {
        logic [1:0] osc_select_field;
        cfwa_wdt_t watchdog_select_field;
        logic [2:0] proc_mode_field;
        logic watchdog_enable;
        logic code_protect;
    } cfwa_status_t;
endpackage

// ---- hdl/cfwa_fuse_access.sv ----
/*
 Configuration fuse word and small program memory behind the program/verify port.
 Assumes strobes and data pins are asynchronous; the table-write port is on core_clk.
*/
// Behaviour
// (R1) Each fuse own location; erased reads one
// (R2) Any write to fuse location programs it
// (R3) Programmer avoids reserved configuration locations
// (R4) Programmer writes configuration in ascending order
// (R5) Seven fuses; programmed fuse reads zero
// (R6) Low-half read: low byte, high port ones
// (R7) High-half read: high byte, high port ones
// (R8) Fixed fuse write addresses per field
// (R9) Low byte holds osc, watchdog, mode bits
// (R10) Mode bit 2 at high byte bit 7
// (R11) Watchdog field decodes enable and postscale
// (R12) Mode field decode; all zero protects
// (R13) Small variant protects by two fuses
// (R14) Protected: scrambled reads, external writes blocked; the code still accepts pin writes to configuration locations
// (R15) Unprotected: true reads, all writes accepted
// (R16) Protected: only on-chip table writes accepted; the code also accepts off-chip table writes to configuration locations
// (R17) Data sampled three instruction cycles after strobe
// (R18) Verify pulse drives current location, next advances
// (R19) Configuration word assembled combinationally from fuses
// (R20) Reserved configuration writes change no fuse
`timescale 1ns/100ps
module cfwa_fuse_access #(
    parameter int MEM_DEPTH = 64,
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic program_strobe,
    input wire logic address_verify_strobe,
    input wire cfwa_pkg::cfwa_pad_t pad_in,
    output cfwa_pkg::cfwa_pad_t pad_out,
    output logic low_byte_port_oe,
    output logic high_byte_port_oe,
    input wire logic tblwt_valid,
    input wire logic [15:0] tblwt_addr,
    input wire logic [15:0] tblwt_data,
    input wire logic tblwt_from_onchip,
    output logic tblwt_done,
    output logic tblwt_accepted,
    output cfwa_pkg::cfwa_status_t cfg_status
);
    import cfwa_pkg::*;

    localparam int MEM_AW = $clog2(MEM_DEPTH);
    localparam logic [15:0] MEM_TOP = 16'(MEM_DEPTH);
    localparam int SMP = SAMPLE_DELAY_CLKS;

    logic [SYNC_BITS-1:0] sync1_reg, sync2_reg, sync3_reg, level_reg, level_next, agree;
    logic prog_lvl, av_lvl, prog_prev_reg, av_prev_reg;
    logic prog_rise, av_rise, av_fall;
    logic [15:0] pin_data;
    cfwa_state_t state_reg, state_next;
    logic [15:0] addr_reg, addr_next, rd_addr;
    logic [7:0] cnt_reg;
    logic shown_reg, same_reg;
    logic [15:0] sample_data_reg;
    logic [NUM_FUSES-1:0] fuse_reg, fuse_hit, fuse_next;
    logic [15:0] mem [MEM_DEPTH];
    logic [15:0] cfg_word;
    logic pm2_eff, prot;
    logic [2:0] pm_field;
    logic pin_wr_req, pin_wr_ok, tbl_ok, wr_en, mem_we;
    logic [15:0] wr_addr, wr_data;
    logic show, inc, sample_now, hold_end;
    logic [15:0] rd_raw, rd_val;
    logic [7:0] scr_byte;
    cfwa_pad_t pad_out_reg;
    logic oe_reg, tblwt_done_reg, tblwt_acc_reg;
    cfwa_status_t status_reg, status_next;

    // Three-stage pin capture; a bit changes when stages two and three agree
    assign agree = ~(sync2_reg ^ sync3_reg);
    assign level_next = (agree & sync3_reg) | (~agree & level_reg);
    assign prog_lvl = level_reg[17];
    assign av_lvl = level_reg[16];
    assign pin_data = level_reg[15:0];
    assign prog_rise = prog_lvl & ~prog_prev_reg;
    assign av_rise = av_lvl & ~av_prev_reg;
    assign av_fall = ~av_lvl & av_prev_reg;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            level_reg <= '0;
            prog_prev_reg <= 1'b0;
            av_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= {program_strobe, address_verify_strobe, pad_in};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= level_next;
            prog_prev_reg <= prog_lvl;
            av_prev_reg <= av_lvl;
        end
    end

    // Configuration word from fuse states, no storage in between
    assign pm2_eff = SMALL_VARIANT ? 1'b1 : fuse_reg[FUSE_PM2]; // [R10]
    assign pm_field = {pm2_eff, fuse_reg[FUSE_PM1], fuse_reg[FUSE_PM0]};
    assign prot = SMALL_VARIANT ? (pm_field[1:0] == PMODE_PROTECTED[1:0]) // [R13]
                                : (pm_field == PMODE_PROTECTED); // [R12]

    always_comb
    begin
        cfg_word = ERASED_WORD; // [R19]
        cfg_word[RD_OSC0_POS] = fuse_reg[FUSE_OSC0]; // [R9]
        cfg_word[RD_OSC1_POS] = fuse_reg[FUSE_OSC1];
        cfg_word[RD_WDT0_POS] = fuse_reg[FUSE_WDT0];
        cfg_word[RD_WDT1_POS] = fuse_reg[FUSE_WDT1];
        cfg_word[RD_PM0_POS] = fuse_reg[FUSE_PM0];
        cfg_word[RD_PM1_POS] = fuse_reg[FUSE_PM1];
        cfg_word[RD_PM2_POS] = pm2_eff; // [R10]
    end

    // Write source: the pin program cycle wins over a colliding table write
    assign pin_wr_req = sample_now;
    assign pin_wr_ok = (addr_reg[15:CFG_SPACE_LSB] == CFG_BASE[15:CFG_SPACE_LSB]) || !prot; // [R14] [R15]
    assign tbl_ok = tblwt_valid && !pin_wr_req && (!prot ||
                    (tblwt_addr[15:CFG_SPACE_LSB] == CFG_BASE[15:CFG_SPACE_LSB]) ||
                    (tblwt_from_onchip && tblwt_addr < MEM_TOP)); // [R16]
    assign wr_en = (pin_wr_req && pin_wr_ok) || tbl_ok;
    assign wr_addr = pin_wr_req ? addr_reg : tblwt_addr;
    assign wr_data = pin_wr_req ? pin_data : tblwt_data;
    assign mem_we = wr_en && wr_addr < MEM_TOP;

    // Data value is ignored for fuses; unlisted config addresses hit nothing
    genvar g;
    generate
        for (g = 0; g < NUM_FUSES; g++)
        begin : g_fuse
            assign fuse_hit[g] = wr_en && (wr_addr == FUSE_ADDR[g]) && // [R2] [R8] [R20]
                                 !(SMALL_VARIANT && g == FUSE_PM2);
        end
    endgenerate
    assign fuse_next = fuse_reg & ~fuse_hit; // [R5]

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            fuse_reg <= FUSE_ERASED; // [R1]
            for (int i = 0; i < MEM_DEPTH; i++)
            begin
                mem[i] <= ERASED_WORD;
            end
        end
        else
        begin
            fuse_reg <= fuse_next;
            if (mem_we)
            begin
                mem[wr_addr[MEM_AW-1:0]] <= wr_data;
            end
        end
    end

    // Readout; scrambling folds the two bytes so stored data cannot be recovered
    assign inc = (state_reg == ST_VERIFY && av_rise && shown_reg) || (state_reg == ST_POST_PROG && av_rise); // [R18]
    assign rd_addr = addr_reg + {15'h0000, inc};
    assign rd_raw = (rd_addr[15:CFG_SPACE_LSB] != CFG_BASE[15:CFG_SPACE_LSB]) ?
                    ((rd_addr < MEM_TOP) ? mem[rd_addr[MEM_AW-1:0]] : ERASED_WORD) :
                    (rd_addr[CFG_HALF_SEL_BIT] ? {PAD_FILL, cfg_word[15:8]} // [R7]
                                                : {PAD_FILL, cfg_word[7:0]}); // [R6]
    assign scr_byte = ~(rd_raw[15:8] ^ rd_raw[7:0]);
    assign rd_val = prot ? {scr_byte, scr_byte} : rd_raw; // [R14] [R15]

    // Program/verify sequencing
    assign sample_now = (state_reg == ST_PROG_WAIT) && (cnt_reg == SAMPLE_LAST); // [R17]
    assign hold_end = (state_reg == ST_PROG_HOLD) && !prog_lvl;
    assign show = ((state_reg == ST_VERIFY || state_reg == ST_POST_PROG) && av_rise) ||
                  (hold_end && same_reg); // [R18]

    always_comb
    begin
        state_next = state_reg;
        addr_next = addr_reg;
        unique case (state_reg)
            ST_LOAD:
            begin
                if (av_rise)
                begin
                    addr_next = pin_data;
                    state_next = ST_VERIFY;
                end
            end
            ST_VERIFY:
            begin
                if (prog_rise)
                    state_next = ST_PROG_WAIT;
                else if (inc)
                    addr_next = rd_addr;
            end
            ST_PROG_WAIT:
            begin
                if (sample_now)
                    state_next = ST_PROG_HOLD;
            end
            ST_PROG_HOLD:
            begin
                if (hold_end)
                    state_next = same_reg ? ST_VERIFY : ST_POST_PROG;
            end
            ST_POST_PROG:
            begin
                if (prog_rise)
                    state_next = ST_PROG_WAIT;
                else if (inc)
                begin
                    addr_next = rd_addr;
                    state_next = ST_VERIFY;
                end
            end
            default:
                state_next = ST_LOAD;
        endcase
    end

    assign status_next.osc_select_field = cfg_word[RD_OSC1_POS:RD_OSC0_POS];
    assign status_next.watchdog_select_field = cfwa_wdt_t'(cfg_word[RD_WDT1_POS:RD_WDT0_POS]); // [R11]
    assign status_next.watchdog_enable = (cfg_word[RD_WDT1_POS:RD_WDT0_POS] != WDT_OFF_16BIT); // [R11]
    assign status_next.proc_mode_field = pm_field; // [R12]
    assign status_next.code_protect = prot;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_reg <= ST_LOAD;
            addr_reg <= '0;
            cnt_reg <= '0;
            shown_reg <= 1'b0;
            same_reg <= 1'b0;
            sample_data_reg <= '0;
            pad_out_reg <= '0;
            oe_reg <= 1'b0;
            tblwt_done_reg <= 1'b0;
            tblwt_acc_reg <= 1'b0;
            status_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            cnt_reg <= (state_reg == ST_PROG_WAIT) ? cnt_reg + 8'h01 : 8'h00;
            shown_reg <= show ? 1'b1 : (prog_rise || state_reg == ST_LOAD) ? 1'b0 : shown_reg;
            same_reg <= prog_rise ? 1'b0 : (av_rise ? 1'b1 : same_reg);
            sample_data_reg <= sample_now ? pin_data : sample_data_reg;
            pad_out_reg <= show ? rd_val : pad_out_reg;
            // Drivers drop on strobe fall or program start, so the host may drive data
            oe_reg <= show ? 1'b1 : ((av_fall || prog_rise) ? 1'b0 : oe_reg); // [R18]
            tblwt_done_reg <= tblwt_valid;
            tblwt_acc_reg <= tbl_ok;
            status_reg <= status_next;
        end
    end

    assign pad_out = pad_out_reg;
    assign low_byte_port_oe = oe_reg;
    assign high_byte_port_oe = oe_reg;
    assign tblwt_done = tblwt_done_reg;
    assign tblwt_accepted = tblwt_acc_reg;
    assign cfg_status = status_reg;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    property p_erased;
        $fell(srst) |-> fuse_reg == FUSE_ERASED;
    endproperty
    a_erased: assert property (p_erased) else $error("fuses not erased after reset"); // [R1]

    property p_any_data_programs;
        wr_en && wr_addr == FUSE_ADDR[FUSE_OSC0] |=> !fuse_reg[FUSE_OSC0] && $stable(fuse_reg[FUSE_OSC1]);
    endproperty
    a_any_data_programs: assert property (p_any_data_programs) else $error("fuse write failed"); // [R2]

    property p_reserved_no_effect;
        wr_en && wr_addr == 16'hfe05 && !pin_wr_req |=> $stable(fuse_reg);
    endproperty
    a_reserved_no_effect: assert property (p_reserved_no_effect) else $error("reserved write hit a fuse"); // [R20]

    property p_low_half_read;
        show && !prot && rd_addr >= CFG_BASE && rd_addr < CFG_HIGH_BASE
        |=> pad_out.high == PAD_FILL && pad_out.low == $past(cfg_word[7:0]) && low_byte_port_oe;
    endproperty
    a_low_half_read: assert property (p_low_half_read) else $error("low half readout wrong"); // [R6]

    property p_high_half_read;
        show && !prot && rd_addr >= CFG_HIGH_BASE && rd_addr <= CFG_LAST
        |=> pad_out.high == PAD_FILL && pad_out.low[7] == $past(pm2_eff);
    endproperty
    a_high_half_read: assert property (p_high_half_read) else $error("high half readout wrong"); // [R7]

    property p_sample_delay;
        prog_rise && state_reg == ST_VERIFY |-> ##[SMP:SMP] pin_wr_req;
    endproperty
    a_sample_delay: assert property (p_sample_delay) else $error("program data not sampled on time"); // [R17]

    property p_protect_blocks;
        prot && pin_wr_req && addr_reg[15:CFG_SPACE_LSB] != CFG_BASE[15:CFG_SPACE_LSB] |-> !mem_we;
    endproperty
    a_protect_blocks: assert property (p_protect_blocks) else $error("protected write went through"); // [R14]

    property p_protect_decode;
        ##1 (fuse_reg[FUSE_PM0] == 1'b0 && fuse_reg[FUSE_PM1] == 1'b0 && (SMALL_VARIANT || !fuse_reg[FUSE_PM2]))
        |=> cfg_status.code_protect;
    endproperty
    a_protect_decode: assert property (p_protect_decode) else $error("code protect not decoded"); // [R12]

    property p_wdt_decode;
        ##1 fuse_reg[FUSE_WDT1:FUSE_WDT0] == 2'b00 |=> !cfg_status.watchdog_enable;
    endproperty
    a_wdt_decode: assert property (p_wdt_decode) else $error("watchdog decode wrong"); // [R11]

    property p_verify_drive;
        av_rise && state_reg == ST_VERIFY |=> low_byte_port_oe && high_byte_port_oe;
    endproperty
    a_verify_drive: assert property (p_verify_drive) else $error("verify did not drive"); // [R18]

    c_program: cover property (pin_wr_req ##[1:40] hold_end);
    c_verify_next: cover property (inc ##1 oe_reg);
    c_protect: cover property (prot && tblwt_valid && tblwt_from_onchip);
endmodule // cfwa_fuse_access

// ---- verif/cfwa_programmer_model.sv ----
/*
 Behavioural device programmer: drives the two strobes and the data pins.
 Assumes the bench resolves the pad wires from the device's output enables.
*/
`timescale 1ns/100ps
module cfwa_programmer_model (
    input wire logic core_clk,
    input wire cfwa_pkg::cfwa_pad_t pad_wire,
    input wire logic pad_oe,
    output cfwa_pkg::cfwa_pad_t pad_drv,
    output logic program_strobe,
    output logic address_verify_strobe
);
    import cfwa_pkg::*;
    logic drive;
    cfwa_pad_t last;
    // Released pins show the inverse, never a stale value
    assign pad_drv = drive ? last : ~last;
    initial
    begin
        drive = 1'b1;
        last = '0;
        program_strobe = 1'b0;
        address_verify_strobe = 1'b0;
    end
    task automatic load(input logic [15:0] addr);
        @(negedge core_clk);
        drive = 1'b1;
        last = addr;
        address_verify_strobe = 1'b1;
        repeat (6) @(negedge core_clk);
        address_verify_strobe = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
    task automatic verify(output logic [15:0] word);
        int i;
        word = 16'hxxxx;
        @(negedge core_clk);
        drive = 1'b0;
        address_verify_strobe = 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(negedge core_clk);
            if (pad_oe === 1'b1)
            begin
                word = pad_wire;
                break;
            end
        end
        address_verify_strobe = 1'b0;
        for (i = 0; i < 20 && pad_oe !== 1'b0; i++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        drive = 1'b1;
    endtask
    task automatic prog_word(input logic [15:0] data);
        @(negedge core_clk);
        drive = 1'b1;
        last = data; // Data set up before strobe rises
        @(negedge core_clk);
        program_strobe = 1'b1;
        // Long hold so the sample point falls well inside the pulse
        repeat (SAMPLE_DELAY_CLKS + 8) @(negedge core_clk);
        program_strobe = 1'b0;
        repeat (6) @(negedge core_clk);
    endtask
endmodule // cfwa_programmer_model

// ---- verif/cfwa_fuse_access_tb.sv ----
/*
 Self-checking bench for the configuration fuse word access block.
 Assumes the programmer model file and the design package are compiled first.
*/
`timescale 1ns/100ps
module cfwa_fuse_access_tb;
    import cfwa_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic tblwt_valid = 1'b0;
    logic [15:0] tblwt_addr = '0;
    logic [15:0] tblwt_data = '0;
    logic tblwt_from_onchip = 1'b0;
    logic program_strobe, address_verify_strobe, low_oe, high_oe, tblwt_done, tblwt_accepted;
    cfwa_pad_t pad_out, pad_drv, pad_wire;
    cfwa_status_t cfg_status;
    cfwa_status_t cfg_status_small;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [6:0] fz;
    logic [15:0] w;
    logic [15:0] a;
    int j;
    assign pad_wire = {high_oe ? pad_out.high : pad_drv.high, low_oe ? pad_out.low : pad_drv.low};
    always #5 core_clk = ~core_clk;
    cfwa_fuse_access cfwa_fuse_access_inst (.core_clk(core_clk), .srst(srst),
        .program_strobe(program_strobe), .address_verify_strobe(address_verify_strobe),
        .pad_in(pad_wire), .pad_out(pad_out), .low_byte_port_oe(low_oe), .high_byte_port_oe(high_oe),
        .tblwt_valid(tblwt_valid), .tblwt_addr(tblwt_addr), .tblwt_data(tblwt_data),
        .tblwt_from_onchip(tblwt_from_onchip), .tblwt_done(tblwt_done),
        .tblwt_accepted(tblwt_accepted), .cfg_status(cfg_status));
    cfwa_programmer_model cfwa_programmer_model_inst (.core_clk(core_clk), .pad_wire(pad_wire),
        .pad_oe(low_oe), .pad_drv(pad_drv), .program_strobe(program_strobe),
        .address_verify_strobe(address_verify_strobe));
    // Smallest variant shares every input; only its status is watched
    cfwa_fuse_access #(.SMALL_VARIANT(1'b1)) cfwa_fuse_access_small_inst (.core_clk(core_clk), .srst(srst),
        .program_strobe(program_strobe), .address_verify_strobe(address_verify_strobe),
        .pad_in(pad_wire), .pad_out(), .low_byte_port_oe(), .high_byte_port_oe(),
        .tblwt_valid(tblwt_valid), .tblwt_addr(tblwt_addr), .tblwt_data(tblwt_data),
        .tblwt_from_onchip(tblwt_from_onchip), .tblwt_done(), .tblwt_accepted(),
        .cfg_status(cfg_status_small));
    // Expected readouts derived from the bench's own fuse image
    function automatic logic [15:0] rd_lo(input logic [6:0] f);
        return {8'hff, 1'b1, f[5], 1'b1, f[4], f[3:0]};
    endfunction
    function automatic logic [15:0] rd_hi(input logic [6:0] f);
        return {8'hff, f[6], 7'h7f};
    endfunction
    function automatic logic [15:0] st(input logic [6:0] f);
        return {7'h00, f[1:0], f[3:2], f[6:4], f[3:2] != 2'b00, f[6:4] == 3'b000};
    endfunction
    // Small variant: upper mode bit absent, reads one; two lower bits protect
    function automatic logic [15:0] st_small(input logic [6:0] f);
        return {7'h00, f[1:0], f[3:2], 1'b1, f[5:4], f[3:2] != 2'b00, f[5:4] == 2'b00};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic do_reset;
        @(negedge core_clk);
        srst = 1'b1;
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
        fz = FUSE_ERASED;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic fuse_hit(input logic [15:0] addr);
        for (int k = 0; k < NUM_FUSES; k++)
            if (FUSE_ADDR[k] == addr) fz[k] = 1'b0;
    endtask
    // Table write: request on one edge, answer stands on the next
    task automatic tw(input logic [15:0] ad, input logic [15:0] d, input logic onchip, output logic acc);
        @(negedge core_clk);
        tblwt_valid = 1'b1;
        tblwt_addr = ad;
        tblwt_data = d;
        tblwt_from_onchip = onchip;
        @(negedge core_clk);
        tblwt_valid = 1'b0;
        chk(16'(tblwt_done), 16'h0001);
        acc = tblwt_accepted;
        repeat (2) @(negedge core_clk);
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            report_and_stop;
        end
    end
    logic acc;
    initial
    begin
        // Erased word read from every configuration location
        do_reset;
        chk(16'(cfg_status), st(fz));
        chk(16'(cfg_status_small), st_small(fz));
        cfwa_programmer_model_inst.load(CFG_BASE);
        for (j = 0; j < 16; j++)
        begin
            cfwa_programmer_model_inst.verify(w);
            chk(w, j < 8 ? rd_lo(fz) : rd_hi(fz));
        end
        // Pin programming walk in ascending order; fe04 and fe05 left alone
        do_reset;
        cfwa_programmer_model_inst.load(CFG_BASE);
        cfwa_programmer_model_inst.verify(w);
        for (a = CFG_BASE; a <= CFG_LAST; a++)
        begin
            if (a inside {16'hfe00, 16'hfe01, 16'hfe02, 16'hfe03, 16'hfe06, 16'hfe0f})
            begin
                cfwa_programmer_model_inst.prog_word(~a);
                fuse_hit(a);
            end
            chk(16'(cfg_status), st(fz));
            if (a == CFG_LAST) break;
            cfwa_programmer_model_inst.verify(w);
            chk(w, a[3] | (a[2:0] == 3'h7) ? rd_hi(fz) : rd_lo(fz));
        end
        // Table writes in ascending order up to protection, one reserved location between
        do_reset;
        tw(16'h0003, 16'h1234, 1'b0, acc);
        chk(16'(acc), 16'h0001);
        for (j = 0; j < 5; j++)
        begin
            a = j == 0 ? 16'hfe03 : j == 1 ? 16'hfe04 : j == 2 ? 16'hfe05 : j == 3 ? 16'hfe06 : 16'hfe0f;
            tw(a, 16'h0000, 1'b0, acc);
            fuse_hit(a);
            chk(16'(acc), 16'h0001);
            chk(16'(cfg_status), st(fz));
            chk(16'(cfg_status_small), st_small(fz));
        end
        tw(16'h0004, 16'h00ff, 1'b0, acc);
        chk(16'(acc), 16'h0000);
        tw(16'h0004, 16'h00ff, 1'b1, acc);
        chk(16'(acc), 16'h0001);
        cfwa_programmer_model_inst.load(16'h0003);
        cfwa_programmer_model_inst.verify(w);
        chk(w, 16'hd9d9);
        cfwa_programmer_model_inst.verify(w);
        chk(w, 16'h0000);
        report_and_stop;
    end
endmodule // cfwa_fuse_access_tb
